// File: host_model.sv
// host side model: one exchange pulse per request
`timescale 1ns/10ps
module host_model (
   input wire logic sys_clk,  // clock
   input wire logic link_en,  // device answers
   input wire logic req,      // bench asks
   output logic     activity  // exchange pulse
);
   // host talks only on request, and only while link is up
   initial
   begin
      activity = 1'b0;
      forever @(posedge sys_clk) activity <= req && link_en;
   end
endmodule // host_model

// File: post_seq.sv
// power-on sequencer: switch capture, test flow and front-panel leds
`timescale 1ns/10ps
module post_seq #(
   parameter logic [39:0] HW_TEST_CYCLES  = post_seq_pkg::HW_TEST_CYC,
   parameter logic [39:0] FULL_ERT_CYCLES = post_seq_pkg::FULL_ERT_CYC,
   parameter logic [39:0] FLASH_CYCLES    = post_seq_pkg::FLASH_CYC
) (
   input  wire logic                       sys_clk,          // 10 MHz clock
   input  wire logic                       nrst,             // power-on reset, low
   input  wire post_seq_pkg::switch_t      switch_pins,      // rear switch segments
   input  wire logic                       latch_engaged,    // head latch in ship pos
   input  wire logic                       hw_test_done,     // test series finished
   input  wire logic                       hw_test_pass,     // with done: all passed
   input  wire logic [post_seq_pkg::ASSY_W-1:0] failed_assy, // with done: assembly no.
   input  wire logic                       ert_error,        // data error pulse
   input  wire logic                       host_activity,    // host exchange pulse
   output logic                            hw_test_run,      // test series running
   output logic                            ert_full_run,     // full-volume test
   output logic                            ert_random_run,   // random test loop
   output logic [post_seq_pkg::ADDR_W-1:0] channel_addr,     // bus channel address
   output logic                            online,           // on line to host
   output logic                            host_link_en,     // answer host commands
   output logic                            service_mode,     // service setting latched
   output post_seq_pkg::led_t              led               // front-panel leds
);
   import post_seq_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   switch_t    sw_meta_reg;
   switch_t    sw_sync_reg;
   logic       latch_meta_reg;
   logic       latch_sync_reg;
   logic [1:0] sync_cnt_reg;
   switch_t    sw_cap_reg;
   seq_state_t state_reg;
   seq_state_t state_next;
   logic [39:0] tmr_reg;
   logic       tmr_done;
   logic [ASSY_W-1:0] assy_reg;
   logic       ert_err_reg;
   logic [39:0] flash_reg;
   logic       flash_on;
   led_t       led_next;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // two stages for switch and latch pins
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sw_meta_reg    <= '0;
         sw_sync_reg    <= '0;
         latch_meta_reg <= 1'b0;
         latch_sync_reg <= 1'b0;
      end
      else
      begin
         sw_meta_reg    <= switch_pins;
         sw_sync_reg    <= sw_meta_reg;
         latch_meta_reg <= latch_engaged;
         latch_sync_reg <= latch_meta_reg;
      end
   end

   // wait until the synchroniser holds real pin values
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         sync_cnt_reg <= 2'h0;
      else if (sync_cnt_reg != 2'h3)
         sync_cnt_reg <= sync_cnt_reg + 2'h1;
   end

   // ----------------------------------------------------------------
   // one-time switch capture
   // ----------------------------------------------------------------
   // single capture
   // taken only in the sample state, never again until reset
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         sw_cap_reg <= '0;
      else if (state_reg == ST_SAMPLE && sync_cnt_reg == 2'h3)
         sw_cap_reg <= sw_sync_reg;
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         channel_addr <= ADDR_RST;
      else
         channel_addr <= {sw_cap_reg.channel_addr_segment_a,
                          sw_cap_reg.channel_addr_segment_b,
                          sw_cap_reg.channel_addr_segment_c};
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   assign tmr_done = (tmr_reg == 40'h0);

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ST_SAMPLE:
         begin
            if (sync_cnt_reg == 2'h3)
               state_next = latch_sync_reg ? ST_SERVO_FAULT : ST_HW_TEST;
         end
         ST_HW_TEST:
         begin
            if (hw_test_done && hw_test_pass)
               state_next = sw_cap_reg.test_mode_select_segment ? ST_ERT_FULL
                                                                  : ST_ONLINE;
            else if (hw_test_done || tmr_done)
               state_next = ST_FAULT;
         end
         ST_ERT_FULL:
         begin
            if (tmr_done)
               state_next = ST_ERT_RANDOM;
         end
         ST_ONLINE, ST_FAULT, ST_SERVO_FAULT, ST_ERT_RANDOM:
            state_next = state_reg;
      endcase
   end

   // state register
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         state_reg <= ST_SAMPLE;
      else
         state_reg <= state_next;
   end

   // phase timer: test time limit, then full-volume test length
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         tmr_reg <= 40'h0;
      else if (state_reg == ST_SAMPLE)
         tmr_reg <= HW_TEST_CYCLES - 40'h1;
      else if (state_reg == ST_HW_TEST && state_next == ST_ERT_FULL)
         tmr_reg <= FULL_ERT_CYCLES - 40'h1;
      else if (!tmr_done)
         tmr_reg <= tmr_reg - 40'h1;
   end

   // failed assembly number, kept from the failing report
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         assy_reg <= '0;
      else if (state_reg == ST_HW_TEST && hw_test_done && !hw_test_pass)
         assy_reg <= failed_assy;
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         ert_err_reg <= 1'b0;
      else if ((state_reg == ST_ERT_FULL || state_reg == ST_ERT_RANDOM) && ert_error)
         ert_err_reg <= 1'b1;
   end

   // ----------------------------------------------------------------
   // run and link outputs
   // ----------------------------------------------------------------
   // registered run strobes and host link state
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         hw_test_run    <= 1'b0;
         ert_full_run   <= 1'b0;
         ert_random_run <= 1'b0;
         online         <= 1'b0;
         host_link_en   <= 1'b0;
         service_mode   <= 1'b0;
      end
      else
      begin
         hw_test_run    <= (state_next == ST_HW_TEST);
         ert_full_run   <= (state_next == ST_ERT_FULL);
         ert_random_run <= (state_next == ST_ERT_RANDOM);
         service_mode   <= sw_cap_reg.test_mode_select_segment;
         online         <= (state_next == ST_ONLINE);
         host_link_en   <= !sw_cap_reg.test_mode_select_segment &&
                           (state_next == ST_ONLINE || state_next == ST_FAULT ||
                            state_next == ST_SERVO_FAULT);
      end
   end

   // ----------------------------------------------------------------
   // activity flash
   // ----------------------------------------------------------------
   // green dark spell per exchange
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         flash_reg <= 40'h0;
      else if (host_activity && host_link_en)
         flash_reg <= FLASH_CYCLES;
      else if (flash_reg != 40'h0)
         flash_reg <= flash_reg - 40'h1;
   end

   assign flash_on = (flash_reg != 40'h0);

   // ----------------------------------------------------------------
   // led patterns
   // ----------------------------------------------------------------
   always_comb
   begin
      led_next = LED_OFF;
      unique case (state_reg)
         ST_SAMPLE, ST_HW_TEST:
            led_next = LED_OFF;
         ST_ONLINE:
            led_next.green = !flash_on;
         ST_FAULT:
         begin
            led_next.red                 = 1'b1;
            {led_next.yellow, led_next.green} = FAIL_CODE_TABLE[assy_reg];
            if (flash_on)
               led_next.green = !led_next.green;
         end
         ST_SERVO_FAULT:
         begin
            led_next.red    = 1'b1;
            led_next.yellow = 1'b1;
         end
         ST_ERT_FULL, ST_ERT_RANDOM:
         begin
            led_next.yellow = 1'b1;
            led_next.green  = !ert_err_reg;
         end
      endcase
   end

   // led flip-flops
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         led <= LED_OFF;
      else
         led <= led_next;
   end

endmodule // post_seq

// File: post_seq_chk.sv
// assertion checker for the power-on sequencer outputs
`timescale 1ns/10ps
module post_seq_chk
   import post_seq_pkg::*;
#(
   parameter logic [39:0] FULL_ERT_CYCLES = FULL_ERT_CYC
) (
   input wire logic        sys_clk,        // clock
   input wire logic        nrst,           // reset, low
   input wire logic        ert_error,      // data error
   input wire logic        host_activity,  // host exchange
   input wire logic        hw_test_run,    // tests running
   input wire logic        ert_full_run,   // full test
   input wire logic        ert_random_run, // random loop
   input wire logic [2:0]  channel_addr,   // address
   input wire logic        online,         // on line
   input wire logic        host_link_en,   // link enabled
   input wire logic        service_mode,   // service latched
   input wire led_t        led             // leds
);
   logic [39:0] full_cnt;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // length of the full-volume phase
   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst) full_cnt <= 40'h0;
      else full_cnt <= ert_full_run ? full_cnt + 40'h1 : 40'h0;
   AST_ADDR_HOLD: assert property ($rose(hw_test_run) |=>
      ##1 $stable(channel_addr) [*8])
      else $error("address moved after capture");
   AST_SVC_OFF: assert property (service_mode |-> !online && !host_link_en)
      else $error("service mode on line");
   AST_NO_DIAG: assert property (!service_mode |-> !ert_full_run && !ert_random_run)
      else $error("error-rate test in normal mode");
   AST_GREEN: assert property ($rose(online) |=> led == 3'h1)
      else $error("green not lit after pass");
   AST_RED_OFF: assert property (led.red |-> !online)
      else $error("on line with red lit");
   AST_LINK: assert property (led.red && !service_mode |-> host_link_en)
      else $error("link dropped on fault");
   AST_TEST_DARK: assert property (hw_test_run |-> !online && led == 3'h0)
      else $error("on line during tests");
   AST_ERT_LEDS: assert property ($rose(ert_full_run) |=> led == 3'h3)
      else $error("yellow and green not lit");
   AST_ERT_ERR: assert property ((ert_full_run || ert_random_run) && ert_error
      |-> ##2 (led == 3'h2) [*4])
      else $error("green lit after data error");
   AST_FULL_LEN: assert property ($fell(ert_full_run) |-> ert_random_run
      && full_cnt >= FULL_ERT_CYCLES - 1 && full_cnt <= FULL_ERT_CYCLES + 1)
      else $error("full test length wrong");
   AST_LOOP: assert property (ert_random_run |=> ert_random_run)
      else $error("random loop ended");
   AST_FLASH: assert property (online && host_activity |-> ##[1:2] !led.green)
      else $error("no activity flash");
   COV_ONLINE: cover property (online);
   COV_LOOP: cover property (ert_random_run);
   COV_SERVO: cover property (led == 3'h6);
endmodule // post_seq_chk
bind post_seq post_seq_chk #(.FULL_ERT_CYCLES(FULL_ERT_CYCLES)) u_post_seq_chk (
   .sys_clk(sys_clk), .nrst(nrst), .ert_error(ert_error), .host_activity(host_activity),
   .hw_test_run(hw_test_run), .ert_full_run(ert_full_run), .ert_random_run(ert_random_run),
   .channel_addr(channel_addr), .online(online), .host_link_en(host_link_en),
   .service_mode(service_mode), .led(led));

// File: post_seq_pkg.sv
// constants and types for the power-on sequencer and status display
//
// Function
// - sample all four switch segments once after power-on, hold until power cycle.
// - three address segments together give channel address zero through seven.
// - address segments never launch any diagnostic; address only.
// - mode segment picks normal online or service test routine at power-on.
// - normal setting runs hardware tests, goes online only after pass, about ten seconds.
// - normal setting pass holds the green led steadily lit.
// - test failure keeps red lit, yellow and green carry failed-assembly code.
// - red fault does not stop host link; fault queries still answered.
// - latch engaged at power-up reports servo fault, red and yellow lit.
// - service setting runs same hardware tests but never goes online.
// - service pass runs one full read-only error-rate test, then random ones forever.
// - during service error-rate tests both yellow and green are lit.
// - any data error in service tests turns green off, yellow alone lit.
// - service setting stays offline until power off, mode restored, power on.
// - green flashes whenever data or commands are exchanged with the host; in servo fault green stays dark.
package post_seq_pkg;

   // --------------------------------------------------------------
   // clock and timing
   // --------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned HW_TEST_TIME_S  = 10;       // hardware test series limit
   localparam int unsigned FULL_ERT_TIME_S = 450;      // 7.5 minutes
   localparam int unsigned FLASH_TIME_MS   = 50;       // green dark time per activity
   localparam logic [39:0] HW_TEST_CYC  = 40'(64'(HW_TEST_TIME_S) * CLK_HZ);
   localparam logic [39:0] FULL_ERT_CYC = 40'(64'(FULL_ERT_TIME_S) * CLK_HZ);
   localparam logic [39:0] FLASH_CYC    = 40'(64'(FLASH_TIME_MS) * (CLK_HZ / 1000));

   // --------------------------------------------------------------
   // reset values and field widths
   // --------------------------------------------------------------
   localparam int unsigned ADDR_W    = 3;
   localparam int unsigned ASSY_W    = 3;
   localparam logic [2:0]  ADDR_RST  = 3'h0;

   // --------------------------------------------------------------
   // types
   // --------------------------------------------------------------
   typedef struct packed {
      logic test_mode_select_segment;   // 1 = service test setting
      logic channel_addr_segment_a;     // address bit 2
      logic channel_addr_segment_b;     // address bit 1
      logic channel_addr_segment_c;     // address bit 0
   } switch_t;

   typedef struct packed {
      logic red;
      logic yellow;
      logic green;
   } led_t;

   localparam led_t LED_OFF = 3'h0;

   typedef enum logic [2:0] {
      ST_SAMPLE, ST_HW_TEST, ST_ONLINE, ST_FAULT, ST_SERVO_FAULT, ST_ERT_FULL, ST_ERT_RANDOM
   } seq_state_t;

   // failed assembly number -> {yellow, green}
   localparam logic [1:0] FAIL_CODE_TABLE [8] = '{
      2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h3, 2'h0
   };

endpackage

// File: post_seq_tb.sv
// self-checking bench for the power-on sequencer
`timescale 1ns/10ps
module post_seq_tb;
   import post_seq_pkg::*;
   logic       sys_clk = 0, nrst = 0, latch = 0, done = 0, pass = 0, err = 0, req = 0;
   logic [2:0] assy = 0, addr;
   switch_t    sw = 0;
   logic       hw_run, efull, erand, onl, link, svc, act;
   led_t       led, last = 0;
   int         n_mismatch = 0, n_checks = 0;
   logic [8:0] notes[$];
   logic [8:0] exp_note;
   always #50 sys_clk = ~sys_clk;
   post_seq #(.HW_TEST_CYCLES(40'd50), .FULL_ERT_CYCLES(40'd40), .FLASH_CYCLES(40'd4))
   u_post_seq (.sys_clk(sys_clk), .nrst(nrst), .switch_pins(sw), .latch_engaged(latch),
      .hw_test_done(done), .hw_test_pass(pass), .failed_assy(assy), .ert_error(err),
      .host_activity(act), .hw_test_run(hw_run), .ert_full_run(efull),
      .ert_random_run(erand), .channel_addr(addr), .online(onl), .host_link_en(link),
      .service_mode(svc), .led(led));
   host_model u_host_model (.sys_clk(sys_clk), .link_en(link), .req(req), .activity(act));
   task check(string nm, logic [8:0] s, logic [8:0] e);
      n_checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task note(led_t l, logic o, logic k);
      notes.push_back({l, o, k, sw});
   endtask
   // one power cycle with a test report after d cycles, none if d is 0 or latch l is set
   task automatic boot(switch_t s, logic l, int d, logic p, logic [2:0] a);
      logic [2:0] c;
      c = (d == 0) ? 3'h0 : a;
      @(negedge sys_clk);
      nrst = 0;
      sw = s;
      latch = l;
      if (l) note(3'h6, 0, !s[3]);
      else if (p && d != 0) note(s[3] ? 3'h3 : 3'h1, !s[3], !s[3]);
      else note({1'b1, FAIL_CODE_TABLE[c]}, 0, !s[3]);
      repeat (3) @(negedge sys_clk);
      nrst = 1;
      if (!l)
      begin
         for (int i = 0; i < 9 && !hw_run; i++) @(negedge sys_clk);
         check("test_run", 9'(hw_run), 9'h1);
         repeat (d) @(negedge sys_clk);
         done = (d != 0);
         pass = p;
         assy = a;
         @(negedge sys_clk);
         done = 0;
      end
      repeat (60) @(negedge sys_clk);
   endtask
   // result watcher: every led change takes the oldest note
   always @(negedge sys_clk)
   begin
      if (nrst && led !== last)
      begin
         exp_note = notes.size() ? notes.pop_front() : 9'bx;
         check("outputs", {led, onl, link, svc, addr}, exp_note);
      end
      last = led;
   end
   initial
   begin
      #2000000;
      n_mismatch++;
      tally_and_finish;
   end
   initial
   begin
      logic [3:0] s0;
      void'($urandom(89));
      repeat (3) @(negedge sys_clk);
      boot(4'($urandom % 8), 0, 1 + $urandom % 8, 1, 3'h0);
      note(3'h0, 1, 1);
      note(3'h1, 1, 1);
      req = 1;
      @(negedge sys_clk);
      req = 0;
      s0 = sw;
      sw = ~sw;
      repeat (20) @(negedge sys_clk);
      check("latched", {5'h0, svc, addr}, {5'h0, s0});
      for (int a = 0; a < 8; a++) boot(4'($urandom % 8), 0, 2, 0, 3'(a));
      boot(4'h5, 0, 0, 0, 3'h4);
      boot(4'h8 | 4'($urandom % 8), 0, 3, 1, 3'h0);
      check("ert", {7'h0, efull, erand}, 9'h1);
      note(3'h2, 0, 0);
      err = 1;
      @(negedge sys_clk);
      err = 0;
      repeat (5) @(negedge sys_clk);
      boot(4'hF, 0, 4, 0, 3'h6);
      boot(4'h3, 1, 1, 1, 3'h0);
      boot(4'h6, 0, 5, 1, 3'h0);
      check("pending", 9'(notes.size()), 9'h0);
      tally_and_finish;
   end
endmodule // post_seq_tb
